// ### reset_irq_source.sv
// far side model: reset pin driver and interrupt request lines.
// assumes a 100 MHz clock, so 1000 cycles make the 10 us minimum.
`timescale 1ns/10ps
`default_nettype none
module reset_irq_source #(
    parameter int LOW_CYC = 1000        // pin low time in cycles
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_go,   // start one reset pulse
    input  wire logic [7:0] i_irq_go,   // request pulses to raise
    output wire logic       o_rst_pin_n,
    output wire logic [7:0] o_int_req
);
    int cnt = 0;                        // low cycles still to go
    // a short pulse would be no valid reset, so the full time is kept
    always @(posedge i_clk) begin
        if (i_rst_go) cnt <= LOW_CYC;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign o_rst_pin_n = (cnt == 0);    // pulled high when released
    assign o_int_req = i_irq_go;
endmodule // reset_irq_source
`default_nettype wire

// ### sequencer_defs.vh
// constants for the stop-release and reset sequencer: register map,
// reset values, field positions and stabilisation wait counts.
// assumes i_clk is the selected main oscillator clock itself.
`ifndef SEQUENCER_DEFS_VH
`define SEQUENCER_DEFS_VH

////////////////////////////////////////////////////////////////////////
// register addresses on the 16-bit register port
`define ADDR_STAB_SEL   16'hFFFA
`define ADDR_SUB_PWR    16'hFFAF
`define ADDR_PSW        16'hFF1E
`define ADDR_PCC        16'hFFFB
`define ADDR_SUB_MODE   16'hFF70
`define ADDR_SUB_CTRL   16'hFF72
`define ADDR_INT_MASK   16'hFFE4
`define ADDR_INT_FLAG   16'hFFE0
`define ADDR_EXT_MODE   16'hFFEC
`define ADDR_KEY_MODE   16'hFFF5
`define ADDR_PORT_LAT   16'hFF00
`define ADDR_PORT_DIR   16'hFF20
`define ADDR_PULL_UP    16'hFF32
`define ADDR_RX_BUF     16'hFF19
`define ADDR_TMR_MODE   16'hFF50

////////////////////////////////////////////////////////////////////////
// reset values
`define RST_STAB_SEL    8'h04
`define RST_PSW         8'h02
`define RST_PCC         8'h02
`define RST_ZERO        8'h00
`define RST_ONES        8'hFF

// writable bits of the narrow registers
`define WMASK_STAB_SEL  8'h07
`define WMASK_SUB_PWR   8'h01
`define WMASK_FULL      8'hFF

// interrupt enable bit of the status word
`define PSW_IE_BIT      7

////////////////////////////////////////////////////////////////////////
// stabilisation select codes and wait lengths in oscillator periods
`define SEL_X12         3'h0
`define SEL_X15         3'h2
`define SEL_X17         3'h4
`define WAIT_X12        4096
`define WAIT_X15        32768
`define WAIT_X17        131072
`define WAIT_RC7        128

// reset vector byte addresses
`define VEC_ADDR_LO     16'h0000
`define VEC_ADDR_HI     16'h0001

`endif

// ### stab_wait_counter.v
// down-counter that times one oscillation stabilisation wait.
// assumes i_len is held steady in the cycle i_start is high.
`timescale 1ns/10ps
`default_nettype none

module stab_wait_counter #(
    parameter CW = 18                    // counter width
) (
    input  wire          i_clk,          // main oscillator clock
    input  wire          i_sys_rst,      // synchronous reset, high
    input  wire          i_start,        // load and start the wait
    input  wire [CW-1:0] i_len,          // wait length in cycles
    output wire          o_busy,         // wait in progress
    output wire          o_done          // last cycle of the wait
);

    reg [CW-1:0] cnt_ff;                 // cycles left minus one
    reg          busy_ff;                // counting

    ////////////////////////////////////////////////////////////////////
    // a restart wins over a running wait, so a new reset re-times it
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_ff  <= {CW{1'b0}};
            busy_ff <= 1'b0;
        end else if (i_start) begin
            cnt_ff  <= i_len - {{(CW-1){1'b0}}, 1'b1};
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            // stop at zero rather than wrap into another long wait
            if (cnt_ff == {CW{1'b0}}) begin
                busy_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign o_busy = busy_ff;
    assign o_done = busy_ff && (cnt_ff == {CW{1'b0}});

endmodule // stab_wait_counter

`default_nettype wire

// ### stop_release_and_reset_sequencer.v
// stop-mode release and chip reset sequencer with its register bank.
// assumes all inputs are synchronous to i_clk, which is the selected
// main oscillator; each vector byte we ask for comes back the next cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sequencer_defs.vh"

// Contract
// - enabled interrupt vectors only after wait
// - disabled interrupt resumes at next instruction
// - interrupt wait from select, RC fixed
// - reset in stop waits then resets
// - masked request keeps stop mode
// - reset from pin or watchdog
// - program counter loaded from vector bytes
// - low pin resets all hardware
// - pins high impedance in reset, wait
// - high pin releases, run after wait
// - watchdog reset releases itself
// - both resets act the same; here a watchdog overflow in stop resets at once, without the stop-reset wait
// - reset in stop keeps stop contents
// - reset wait 2^15 crystal or 2^7 RC
// - only program counter undefined meanwhile
// - standby reset keeps memory contents
// - status word and clock control 02H
// - latches 00H, directions FFH, pull-ups 00H
// - flags 00H, masks FFH, modes cleared
// - select 04H, subclock and power 00H
// - receive buffer FFH, timer regs 00H
// - select codes give 2^12, 2^15, 2^17
module stop_release_and_reset_sequencer #(
    parameter N_IRQ      = 8,            // interrupt sources
    parameter P_WAIT_X12 = `WAIT_X12,    // short crystal wait
    parameter P_WAIT_X15 = `WAIT_X15,    // middle crystal wait
    parameter P_WAIT_X17 = `WAIT_X17,    // long crystal wait
    parameter P_WAIT_RC  = `WAIT_RC7     // fixed rc wait
) (
    input  wire             i_clk,        // main oscillator clock
    input  wire             i_sys_rst,    // power-on reset, high
    input  wire             i_rst_pin_n,  // external reset pin, low
    input  wire             i_wdt_ovf,    // watchdog overflow pulse
    input  wire             i_osc_rc,     // 1: rc oscillator in use
    input  wire             i_stop_exec,  // cpu executes stop
    input  wire [N_IRQ-1:0] i_int_req,    // interrupt request pulses
    input  wire             i_rx_load,    // receive byte arrived
    input  wire [7:0]       i_rx_data,    // received byte
    input  wire [7:0]       i_vec_data,   // vector byte, next cycle
    input  wire [15:0]      i_addr,       // register address
    input  wire [7:0]       i_wdata,      // register write data
    input  wire             i_wr,         // write strobe
    input  wire             i_rd,         // read strobe
    output reg  [7:0]       o_rdata,      // read data, next cycle
    output wire             o_vec_rd,     // vector byte request
    output wire [15:0]      o_vec_addr,   // vector byte address
    output wire [15:0]      o_pc,         // program counter
    output wire             o_pc_valid,   // program counter defined
    output wire             o_cpu_run,    // cpu may execute
    output wire             o_stop_mode,  // clock stopped or waking
    output wire             o_pins_hiz,   // all pins high impedance
    output wire             o_hw_reset,   // reset to other blocks
    output reg              o_int_service,// vectored service pulse
    output reg              o_resume_next,// resume without vector
    output wire [7:0]       o_port_latch, // port output latch
    output wire [7:0]       o_port_dir,   // port direction, 1 input
    output wire [7:0]       o_pull_up     // pull-up enables
);

    ////////////////////////////////////////////////////////////////////
    // register indices into the bank
    localparam [3:0] R_STAB = 4'h0;       // stabilization_time_select
    localparam [3:0] R_PWR  = 4'h1;       // subclock_power_select
    localparam [3:0] R_PSW  = 4'h2;       // processor_status_word
    localparam [3:0] R_PCC  = 4'h3;       // processor_clock_control
    localparam [3:0] R_SUBCLOCK_OSCILLATION_MODE = 4'h4;       // subclock_oscillation_mode
    localparam [3:0] R_SUBC = 4'h5;       // subclock_control
    localparam [3:0] R_MASK = 4'h6;       // interrupt_mask_flag
    localparam [3:0] R_IRQF = 4'h7;       // interrupt request flags
    localparam [3:0] R_EXTM = 4'h8;       // external_int_mode
    localparam [3:0] R_KEYM = 4'h9;       // key_return_mode
    localparam [3:0] R_LAT  = 4'hA;       // port output latch
    localparam [3:0] R_DIR  = 4'hB;       // port_direction_reg
    localparam [3:0] R_PULL = 4'hC;       // pull-up option
    localparam [3:0] R_RXB  = 4'hD;       // serial_receive_buffer
    localparam [3:0] R_TMR  = 4'hE;       // timer mode control
    localparam [3:0] R_NONE = 4'hF;       // unmapped address
    localparam       NREG   = 15;         // registers in the bank

    ////////////////////////////////////////////////////////////////////
    // one-hot sequencer states
    localparam [8:0] ST_RESET = 9'h001;   // reset held
    localparam [8:0] ST_WAIT  = 9'h002;   // wait after reset release
    localparam [8:0] ST_VLO   = 9'h004;   // ask for vector low byte
    localparam [8:0] ST_VHI   = 9'h008;   // ask for vector high byte
    localparam [8:0] ST_VEND  = 9'h010;   // take vector high byte
    localparam [8:0] ST_RUN   = 9'h020;   // normal execution
    localparam [8:0] ST_STOP  = 9'h040;   // oscillator stopped
    localparam [8:0] ST_IWAIT = 9'h080;   // wait after interrupt wake
    localparam [8:0] ST_SRST  = 9'h100;   // reset pin low in stop

    localparam CW = 18;                   // wait counter width

    ////////////////////////////////////////////////////////////////////
    // wait lengths cut to the counter width
    localparam [CW-1:0] LEN_X12 = P_WAIT_X12[CW-1:0];
    localparam [CW-1:0] LEN_X15 = P_WAIT_X15[CW-1:0];
    localparam [CW-1:0] LEN_X17 = P_WAIT_X17[CW-1:0];
    localparam [CW-1:0] LEN_RC  = P_WAIT_RC[CW-1:0];

    reg  [8:0]    st_ff;                  // current state
    reg  [8:0]    nxt_st;                 // next state
    reg           from_stop_ff;           // wait follows a stop reset
    reg           nxt_from_stop;          // next from_stop_ff
    reg  [15:0]   pc_ff;                  // program counter
    reg  [7:0]    regs_ff [0:NREG-1];     // register bank
    reg           wait_start;             // start the wait counter
    reg  [CW-1:0] wait_len;               // its length
    wire          wait_done;              // last wait cycle
    wire          rst_req;                // any reset source active
    wire          pend;                   // unmasked request pending
    wire          ie;                     // interrupt enable bit
    wire          hw_rst;                 // force reset values now
    wire [3:0]    wr_idx;                 // write target
    wire [3:0]    rd_idx;                 // read target
    wire          wr_hit;                 // accepted write
    integer       i;                      // bank loop index

    ////////////////////////////////////////////////////////////////////
    // address decode; anything unlisted is unmapped
    function [3:0] addr_idx;
        input [15:0] a;
        begin
            case (a)
                `ADDR_STAB_SEL: addr_idx = R_STAB;
                `ADDR_SUB_PWR:  addr_idx = R_PWR;
                `ADDR_PSW:      addr_idx = R_PSW;
                `ADDR_PCC:      addr_idx = R_PCC;
                `ADDR_SUB_MODE: addr_idx = R_SUBCLOCK_OSCILLATION_MODE;
                `ADDR_SUB_CTRL: addr_idx = R_SUBC;
                `ADDR_INT_MASK: addr_idx = R_MASK;
                `ADDR_INT_FLAG: addr_idx = R_IRQF;
                `ADDR_EXT_MODE: addr_idx = R_EXTM;
                `ADDR_KEY_MODE: addr_idx = R_KEYM;
                `ADDR_PORT_LAT: addr_idx = R_LAT;
                `ADDR_PORT_DIR: addr_idx = R_DIR;
                `ADDR_PULL_UP:  addr_idx = R_PULL;
                `ADDR_RX_BUF:   addr_idx = R_RXB;
                `ADDR_TMR_MODE: addr_idx = R_TMR;
                default:        addr_idx = R_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset value of each register
    function [7:0] rst_val;
        input [3:0] r;
        begin
            case (r)
                R_STAB:  rst_val = `RST_STAB_SEL;
                R_PSW:   rst_val = `RST_PSW;
                R_PCC:   rst_val = `RST_PCC;
                R_MASK:  rst_val = `RST_ONES;
                R_DIR:   rst_val = `RST_ONES;
                R_RXB:   rst_val = `RST_ONES;
                // latches, pull-ups, flags, modes, timer
                default: rst_val = `RST_ZERO;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // writable bits; the rest hold, and in select and power read back as zero
    function [7:0] wr_mask;
        input [3:0] r;
        begin
            case (r)
                R_STAB:  wr_mask = `WMASK_STAB_SEL;
                R_PWR:   wr_mask = `WMASK_SUB_PWR;
                R_RXB:   wr_mask = `RST_ZERO;     // read only
                default: wr_mask = `WMASK_FULL;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // wait length chosen by the select field on an interrupt wake
    function [CW-1:0] int_len;
        input [2:0] sel;
        begin
            case (sel)
                `SEL_X12: int_len = LEN_X12;
                `SEL_X15: int_len = LEN_X15;
                // prohibited codes take the longest, safest wait
                default:  int_len = LEN_X17;
            endcase
        end
    endfunction

    // pin and watchdog are merged, so both act the same outside stop mode
    assign rst_req = ~i_rst_pin_n | i_wdt_ovf;
    assign ie      = regs_ff[R_PSW][`PSW_IE_BIT];
    // a masked request cannot wake the part
    assign pend    = |(regs_ff[R_IRQF] & ~regs_ff[R_MASK]);
    assign wr_idx  = addr_idx(i_addr);
    assign rd_idx  = addr_idx(i_addr);
    // the cpu alone writes, so writes count only while it runs
    assign wr_hit  = i_wr && (st_ff == ST_RUN) && (wr_idx != R_NONE);

    // reset values are forced through reset and a normal wait; after a
    // stop reset they land only once the wait is over
    assign hw_rst = (st_ff == ST_RESET) ||
        ((st_ff == ST_WAIT) && (~from_stop_ff || wait_done));

    ////////////////////////////////////////////////////////////////////
    // wait timer on the main oscillator clock
    stab_wait_counter #(
        .CW      (CW)
    ) u_wait (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (wait_start),
        .i_len     (wait_len),
        .o_busy    (),
        .o_done    (wait_done)
    );

    ////////////////////////////////////////////////////////////////////
    // next state, and when and how long to wait
    always @* begin
        nxt_st        = st_ff;
        nxt_from_stop = from_stop_ff;
        wait_start    = 1'b0;
        // reset release wait does not follow the select field
        wait_len      = i_osc_rc ? LEN_RC : LEN_X15;
        case (st_ff)
            ST_RESET: begin
                // a watchdog pulse ends by itself, the pin on going high
                if (!rst_req) begin
                    nxt_st     = ST_WAIT;
                    wait_start = 1'b1;
                end
            end
            ST_WAIT: begin
                if (rst_req) begin
                    nxt_st        = ST_RESET;
                    nxt_from_stop = 1'b0;
                end else if (wait_done) begin
                    nxt_st        = ST_VLO;
                    nxt_from_stop = 1'b0;
                end
            end
            ST_VLO, ST_VHI: begin
                if (rst_req) begin
                    nxt_st = ST_RESET;
                end else begin
                    nxt_st = (st_ff == ST_VLO) ? ST_VHI : ST_VEND;
                end
            end
            ST_VEND: begin
                nxt_st = rst_req ? ST_RESET : ST_RUN;
            end
            ST_RUN: begin
                if (rst_req) begin
                    nxt_st = ST_RESET;
                end else if (i_stop_exec) begin
                    nxt_st = ST_STOP;
                end
            end
            ST_STOP, ST_IWAIT: begin
                if (!i_rst_pin_n) begin
                    // pin reset in stop keeps stop contents
                    nxt_st        = ST_SRST;
                    nxt_from_stop = 1'b1;
                end else if (i_wdt_ovf) begin
                    nxt_st = ST_RESET;
                end else if (st_ff == ST_STOP) begin
                    if (pend) begin
                        nxt_st     = ST_IWAIT;
                        wait_start = 1'b1;
                        wait_len   = i_osc_rc ? LEN_RC :
                            int_len(regs_ff[R_STAB][2:0]);
                    end
                end else if (wait_done) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_SRST: begin
                // wait first, reset processing afterwards
                if (i_wdt_ovf) begin
                    nxt_st        = ST_RESET;
                    nxt_from_stop = 1'b0;
                end else if (i_rst_pin_n) begin
                    nxt_st     = ST_WAIT;
                    wait_start = 1'b1;
                end
            end
            default: begin
                nxt_st        = ST_RESET;
                nxt_from_stop = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state registers; power-on reset starts as a pin reset would
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_ff        <= ST_RESET;
            from_stop_ff <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            from_stop_ff <= nxt_from_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wake outcome pulses, one cycle as the cpu restarts
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_int_service <= 1'b0;
            o_resume_next <= 1'b0;
        end else begin
            // vector only once the wait is over
            o_int_service <= (nxt_st == ST_RUN) &&
                (st_ff == ST_IWAIT) && ie;
            o_resume_next <= (nxt_st == ST_RUN) &&
                (st_ff == ST_IWAIT) && !ie;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program counter from the two vector bytes, low first
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            pc_ff <= 16'h0000;
        end else if (st_ff == ST_VHI) begin
            pc_ff[7:0]  <= i_vec_data;
        end else if (st_ff == ST_VEND) begin
            pc_ff[15:8] <= i_vec_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register bank; hardware flag sets win over a software write
    always @(posedge i_clk) begin
        for (i = 0; i < NREG; i = i + 1) begin
            if (i_sys_rst || hw_rst) begin
                regs_ff[i] <= rst_val(i[3:0]);
            end else if (wr_hit && (wr_idx == i[3:0])) begin
                regs_ff[i] <= (i_wdata & wr_mask(i[3:0])) |
                    (regs_ff[i] & ~wr_mask(i[3:0]));
            end
        end
        if (!(i_sys_rst || hw_rst)) begin
            // requests stay latched while stopped so they can wake
            regs_ff[R_IRQF] <= i_int_req |
                ((wr_hit && (wr_idx == R_IRQF)) ? i_wdata :
                regs_ff[R_IRQF]);
            if (i_rx_load) begin
                regs_ff[R_RXB] <= i_rx_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data stand for the one cycle after the strobe
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd && (rd_idx != R_NONE)) begin
            o_rdata <= regs_ff[rd_idx];
        end else begin
            o_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; pin drivers and cpu held until the wait ends
    assign o_vec_rd    = (st_ff == ST_VLO) || (st_ff == ST_VHI);
    assign o_vec_addr  = (st_ff == ST_VHI) ? `VEC_ADDR_HI : `VEC_ADDR_LO;
    assign o_pc        = pc_ff;
    // only the program counter is undefined through reset and wait
    assign o_pc_valid  = (st_ff == ST_RUN) || o_stop_mode;
    assign o_cpu_run   = (st_ff == ST_RUN);
    assign o_stop_mode = (st_ff == ST_STOP) || (st_ff == ST_IWAIT) ||
        (st_ff == ST_SRST);
    assign o_pins_hiz  = (st_ff == ST_RESET) || (st_ff == ST_WAIT) ||
        (st_ff == ST_SRST);
    assign o_hw_reset  = hw_rst;
    assign o_port_latch = regs_ff[R_LAT];
    assign o_port_dir   = regs_ff[R_DIR];
    assign o_pull_up    = regs_ff[R_PULL];

    // a pin pulse shorter than the minimum still resets here; the
    // source must meet the minimum width for a clean oscillator start

endmodule // stop_release_and_reset_sequencer

`default_nettype wire

// ### stop_release_and_reset_sequencer_assertions.sv
// checker on the sequencer ports: reset, wake and fetch timing.
// assumes the shortened crystal reset wait comes in by the bind.
`timescale 1ns/10ps
`default_nettype none
module seq_checker #(
    parameter int P_WAIT_X15 = 32       // crystal reset wait
) (
    input wire logic        i_clk, i_sys_rst, i_rst_pin_n, i_wdt_ovf,
    input wire logic        i_osc_rc, o_vec_rd, o_cpu_run, o_stop_mode,
    input wire logic        o_pins_hiz, o_hw_reset, o_int_service,
    input wire logic        o_resume_next,
    input wire logic [15:0] o_vec_addr,
    input wire logic [7:0]  o_port_dir
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_hiz; !i_rst_pin_n |=> o_pins_hiz; endproperty
    property p_wdt; i_wdt_ovf |=> o_hw_reset && !o_cpu_run; endproperty
    property p_idle; o_pins_hiz |-> !o_cpu_run && !o_vec_rd; endproperty
    property p_vec; $rose(o_vec_rd) |-> o_vec_addr == 16'h0000
        ##1 o_vec_rd && o_vec_addr == 16'h0001; endproperty
    // guarded against a reset in mid-fetch
    property p_go; $fell(o_vec_rd) && !o_pins_hiz && i_rst_pin_n
        && !i_wdt_ovf |=> o_cpu_run; endproperty
    property p_wait; $rose(i_rst_pin_n) && !o_stop_mode && !i_osc_rc
        && !i_wdt_ovf |-> ##P_WAIT_X15 o_pins_hiz ##1 !o_pins_hiz;
    endproperty
    property p_dir; o_hw_reset |=> o_port_dir == 8'hFF; endproperty
    property p_svc; o_int_service |-> o_cpu_run && !o_resume_next
        && $past(o_stop_mode); endproperty
    property p_next; o_resume_next |-> o_cpu_run && $past(o_stop_mode);
    endproperty
    a_hiz: assert property (p_hiz) else $error("pins driven");
    a_wdt: assert property (p_wdt) else $error("no wdt reset");
    a_idle: assert property (p_idle) else $error("run in reset");
    a_vec: assert property (p_vec) else $error("vector order");
    a_go: assert property (p_go) else $error("no run start");
    a_wait: assert property (p_wait) else $error("wait length");
    a_dir: assert property (p_dir) else $error("dir not FF");
    a_svc: assert property (p_svc) else $error("bad service");
    a_next: assert property (p_next) else $error("bad resume");
    c_fetch: cover property ($rose(o_vec_rd));
    c_svc: cover property (o_int_service);
    c_next: cover property (o_resume_next);
endmodule // seq_checker
bind stop_release_and_reset_sequencer seq_checker
    #(.P_WAIT_X15(P_WAIT_X15)) i_seq_checker (.*);
`default_nettype wire

// ### stop_release_and_reset_sequencer_bench.sv
// bench: reset, stop wake and register checks, seeded stimulus.
// assumes shortened waits of 16/32/64 crystal and 8 rc cycles.
`timescale 1ns/10ps
`default_nettype none
module stop_release_and_reset_sequencer_bench;
    logic i_clk = 0, i_sys_rst = 1, i_wdt_ovf = 0, i_osc_rc = 0, i_rd = 0;
    logic i_stop_exec = 0, i_rx_load = 0, i_wr = 0, rst_go = 0;
    logic [7:0] i_rx_data = 0, i_vec_data = 0, i_wdata = 0, irq_go = 0;
    logic [7:0] vlo = 0, vhi = 0, o_rdata, o_port_latch, o_port_dir;
    logic [7:0] o_pull_up, i_int_req;
    logic [15:0] i_addr = 0, o_vec_addr, o_pc;
    logic i_rst_pin_n, o_vec_rd, o_pc_valid, o_cpu_run, o_stop_mode;
    logic o_pins_hiz, o_hw_reset, o_int_service, o_resume_next;
    int fails = 0, checks_done = 0, n;
    logic [15:0] adr [10] = '{16'hFFFA, 16'hFF1E, 16'hFFFB, 16'hFFE4,
        16'hFF20, 16'hFF19, 16'hFFE0, 16'hFF00, 16'hFF32, 16'h1234};
    logic [7:0] rv [10] = '{4, 2, 2, 255, 255, 255, 0, 0, 0, 0};
    logic [7:0] cd [5] = '{0, 2, 4, 7, 4};
    int ln [5] = '{16, 32, 64, 64, 8};
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) i_vec_data <= o_vec_addr[0] ? vhi : vlo;
    stop_release_and_reset_sequencer #(.P_WAIT_X12(16), .P_WAIT_X15(32),
        .P_WAIT_X17(64), .P_WAIT_RC(8)) i_stop_release_and_reset_sequencer
        (.*);
    reset_irq_source i_reset_irq_source (.i_clk(i_clk), .i_rst_go(rst_go),
        .i_irq_go(irq_go), .o_rst_pin_n(i_rst_pin_n), .o_int_req(i_int_req));
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (e !== g) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= d; end
        @(posedge i_clk) i_wr <= 0;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
        @(posedge i_clk) i_rd <= 0;
        #1 chk("rdata", e, o_rdata);
    endtask
    // cycles until the cpu runs
    task automatic to_run(int e);
        n = 0;
        while (o_cpu_run !== 1'b1 && n < 3000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("cycles", e, n);
        if (n >= 3000) give_verdict();
    endtask
    task automatic rst_end(int e);
        to_run(e);
        chk("pc", {vhi, vlo}, o_pc);
        chk("pcv", 1, o_pc_valid);
        chk("dir", 16'hFF, {o_pull_up, o_port_dir});
    endtask
    task automatic pin_reset(logic [7:0] keep);
        vlo = $urandom;
        vhi = $urandom;
        @(posedge i_clk) rst_go <= 1;
        @(posedge i_clk) rst_go <= 0;
        #1 n = 0;
        while (i_rst_pin_n !== 1'b1 && n < 3000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("hiz", 1, o_pins_hiz);
        chk("latch", keep, o_port_latch);
        rst_end(36);
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        n = $urandom(38);
        vlo = $urandom;
        vhi = $urandom;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 0;
        rst_end(36);
        for (int k = 0; k < 10; k++) rd(adr[k], rv[k]);
        wr(16'hFF00, 8'h5A);
        pin_reset(8'h00);
        $display("test done: reset");
        wr(16'hFFE4, 8'hFE);
        for (int k = 0; k < 10; k++) begin
            i_osc_rc <= k > 7;
            wr(16'hFFFA, cd[k / 2]);
            wr(16'hFF1E, {k[0], 7'h02});
            @(posedge i_clk) i_stop_exec <= 1;
            @(posedge i_clk) begin i_stop_exec <= 0; irq_go <= 8'h01; end
            @(posedge i_clk) irq_go <= 0;
            #1 to_run(ln[k / 2] + 1);
            chk("service", k[0], o_int_service);
            chk("resume", !k[0], o_resume_next);
            wr(16'hFFE0, 8'h00);
        end
        $display("test done: wake");
        wr(16'hFF20, 8'h00);
        @(posedge i_clk) i_wdt_ovf <= 1;
        @(posedge i_clk) i_wdt_ovf <= 0;
        #1 rst_end(12);
        $display("test done: watchdog");
        @(posedge i_clk) i_osc_rc <= 0;
        wr(16'hFF00, 8'hC3);
        @(posedge i_clk) i_stop_exec <= 1;
        @(posedge i_clk) begin i_stop_exec <= 0; irq_go <= $urandom; end
        @(posedge i_clk) irq_go <= 0;
        repeat (50) @(posedge i_clk);
        #1 chk("stop kept", 1, o_stop_mode);
        pin_reset(8'hC3);
        $display("test done: stop reset");
        give_verdict();
    end
endmodule // stop_release_and_reset_sequencer_bench
`default_nettype wire
